/* File: design/osc_cal_defines.svh */
`ifndef OSC_CAL_DEFINES_SVH
`define OSC_CAL_DEFINES_SVH
// System clock rate
`define CLK_HZ 20000000
// Crystal health: minimum rate and persistence time
`define XT_MIN_HZ 8000
`define SLOW_CYC (`CLK_HZ / `XT_MIN_HZ)
`define XT_FAIL_MS 32
// Divider chain
`define TICK_HZ 64
`define XT_DIV_LOG2 9
`define CAL_PER_LOG2 19
`define OFS_W 14
`define RANGE_W 2
// Calibration reset value
`define CAL_RST 16'h0000
// Autocalibration timing
`define AC_INT_LONG_S 1024
`define AC_INT_SHORT_S 512
`define AC_XT_ON_S 50
`define AC_WIN_S 16
`define AC_WIN_RC 2048
`define AC_EXP_XT 524288
`define AC_FAIL_MAG 65536
`define ACI_OFF 2'h0
`endif

/* File: design/osc_cal_pkg.sv */
`include "osc_cal_defines.svh"
package osc_cal_pkg;
  // RC calibration setting
  typedef struct packed {
    logic [`RANGE_W-1:0] range;
    logic [`OFS_W-1:0]   offset;
  } rc_cal_t;
  // Autocalibration sequence
  typedef enum logic [1:0] {AC_IDLE, AC_WARM, AC_MEAS, AC_LOAD} ac_state_t;
endpackage : osc_cal_pkg

/* File: design/rc_osc_cal_ctrl.sv */
`include "osc_cal_defines.svh"
module rc_osc_cal_ctrl
  import osc_cal_pkg::*;
#(
  parameter int unsigned FAIL_CYC   = `CLK_HZ / 1000 * `XT_FAIL_MS,
  parameter int unsigned INT_LONG_T = `AC_INT_LONG_S * `TICK_HZ,
  parameter int unsigned INT_SHRT_T = `AC_INT_SHORT_S * `TICK_HZ
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Oscillator and supply pins
  input  wire logic       xt_clk_in,
  input  wire logic       rc_clk_in,
  input  wire logic       supply_low_in,
  // Control
  input  wire logic       osc_select_request,
  input  wire logic       auto_switch_on_supply_loss,
  input  wire logic       failover_on_osc_fail,
  input  wire logic [1:0] autocal_interval,
  input  wire logic       osc_fail_irq_enable,
  input  wire logic       autocal_fail_irq_enable,
  input  wire logic       cal_wr,
  input  wire rc_cal_t    cal_wdata,
  input  wire logic       osc_fail_clr,
  input  wire logic       autocal_fail_clr,
  // Status
  output rc_cal_t         rc_cal,
  output logic            active_osc_indicator,
  output logic            crystal_fail_status,
  output logic            osc_fail_flag,
  output logic            autocal_fail_flag,
  output logic            autocal_busy,
  output logic            crystal_enable,
  output logic            irq,
  output logic            tick_64hz
);
  localparam int unsigned WARM_T = (`AC_XT_ON_S - `AC_WIN_S) * `TICK_HZ;

  // Range picking mirrors the software procedure
  function automatic logic [1:0] pick_range(input logic [21:0] m);
    pick_range = (m >= 22'd32768) ? 2'd3 : (m >= 22'd16384) ? 2'd2 :
                 (m >= 22'd8192) ? 2'd1 : 2'd0;
  endfunction : pick_range

  logic [2:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d, prev_q;
  logic        xt_rise, rc_rise, supply_low;
  logic [11:0] gap_q;
  logic [19:0] fcnt_q;
  logic        xt_slow_q, xt_failed_q, xt_en_q, xt_en_d, act_rc_q, act_rc_d;
  logic        fail_set, stop, ofail_q, afail_q, fstat_q, irq_q;
  rc_cal_t     cal_q;
  logic        ph_q, base64, mid, add_pend_q, tick_q, tick_d;
  logic [8:0]  xdiv_q;
  logic        xt64;
  logic [13:0] mag;
  logic        neg, hit;
  logic [19:0] per_n, acc_q;
  logic [20:0] acc_sum;
  ac_state_t   st_q;
  logic [1:0]  aci_prev_q;
  logic        kick, due;
  logic [16:0] itv_q, itv_lim;
  logic [11:0] wcnt_q;
  logic [21:0] xcnt_q, adj, adj_mag;
  logic        ac_bad;
  rc_cal_t     ac_new;

  // Pin filter: change accepted when stages 2 and 3 agree
  assign lvl_d      = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  assign xt_rise    = lvl_q[0] & ~prev_q[0];
  assign rc_rise    = lvl_q[1] & ~prev_q[1];
  assign supply_low = lvl_q[2];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      s3_q   <= 3'h0;
      lvl_q  <= 3'h0;
      prev_q <= 3'h0;
    end
    else
    begin
      s1_q   <= {supply_low_in, rc_clk_in, xt_clk_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      prev_q <= lvl_q;
    end
  end

  // Oscillator selection and crystal power
  assign stop     = ~osc_select_request & auto_switch_on_supply_loss & supply_low;
  assign act_rc_d = osc_select_request | stop |
                    (failover_on_osc_fail & xt_failed_q);
  assign xt_en_d  = osc_select_request ? (st_q != AC_IDLE) : ~stop;

  // Crystal slow and failure detection
  assign fail_set = xt_en_q & xt_slow_q & ~xt_failed_q &
                    (fcnt_q == 20'(FAIL_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gap_q       <= 12'h000;
      xt_slow_q   <= 1'b1;
      fcnt_q      <= 20'h00000;
      xt_failed_q <= 1'b0;
    end
    else
    begin
      if (xt_rise || !xt_en_q)
        gap_q <= 12'h000;
      else if (gap_q != 12'(`SLOW_CYC - 1))
        gap_q <= gap_q + 12'h001;
      if (xt_rise)
        xt_slow_q <= 1'b0;
      else if (!xt_en_q || gap_q == 12'(`SLOW_CYC - 1))
        xt_slow_q <= 1'b1;
      if (!xt_slow_q || !xt_en_q)
      begin
        fcnt_q      <= 20'h00000;
        xt_failed_q <= 1'b0;
      end
      else if (fail_set)
        xt_failed_q <= 1'b1;
      else if (!xt_failed_q)
        fcnt_q <= fcnt_q + 20'h00001;
    end
  end

  // Flags, status and interrupt request
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ofail_q  <= 1'b1;
      afail_q  <= 1'b0;
      fstat_q  <= 1'b1;
      act_rc_q <= 1'b0;
      xt_en_q  <= 1'b1;
      irq_q    <= 1'b0;
    end
    else
    begin
      ofail_q  <= fail_set | (ofail_q & ~osc_fail_clr);
      afail_q  <= (st_q == AC_LOAD && ac_bad) | (afail_q & ~autocal_fail_clr);
      fstat_q  <= xt_slow_q | act_rc_q;
      act_rc_q <= act_rc_d;
      xt_en_q  <= xt_en_d;
      irq_q    <= (ofail_q & osc_fail_irq_enable) |
                  (afail_q & autocal_fail_irq_enable);
    end
  end

  // 64 Hz stage and distributed calibration
  assign base64  = rc_rise & ph_q;
  assign mid     = rc_rise & ~ph_q;
  assign xt64    = xt_rise & (xdiv_q == 9'h1ff);
  assign neg     = cal_q.offset[`OFS_W-1];
  assign mag     = neg ? 14'(-cal_q.offset) : cal_q.offset;
  assign per_n   = 20'h80000 >> cal_q.range;
  assign acc_sum = {1'b0, acc_q} + {7'h00, mag};
  assign hit     = act_rc_q & base64 & (acc_sum >= {1'b0, per_n});
  assign tick_d  = act_rc_q ? ((base64 & ~(hit & neg)) | (mid & add_pend_q))
                            : xt64;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ph_q       <= 1'b0;
      xdiv_q     <= 9'h000;
      acc_q      <= 20'h00000;
      add_pend_q <= 1'b0;
      tick_q     <= 1'b0;
    end
    else
    begin
      if (rc_rise)
        ph_q <= ~ph_q;
      if (xt_rise)
        xdiv_q <= xdiv_q + 9'h001;
      if (!act_rc_q || acc_q >= per_n)
        acc_q <= 20'h00000;
      else if (base64)
        acc_q <= hit ? 20'(acc_sum - {1'b0, per_n}) : acc_sum[19:0];
      if (hit && !neg)
        add_pend_q <= 1'b1;
      else if (mid || !act_rc_q)
        add_pend_q <= 1'b0;
      tick_q <= tick_d;
    end
  end

  // Autocalibration triggers
  assign kick    = (aci_prev_q == `ACI_OFF) && (autocal_interval != `ACI_OFF);
  assign itv_lim = autocal_interval[0] ? 17'(INT_SHRT_T) : 17'(INT_LONG_T);
  assign due     = autocal_interval[1] && tick_q && (itv_q >= itv_lim - 17'h00001);
  assign adj     = 22'(xcnt_q - 22'(`AC_EXP_XT));
  assign adj_mag = adj[21] ? 22'(-adj) : adj;
  assign ac_bad  = adj_mag >= 22'(`AC_FAIL_MAG);
  assign ac_new.range  = pick_range(adj_mag);
  assign ac_new.offset = 14'($signed(adj) >>> pick_range(adj_mag));

  // Interval timer and measurement sequence
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q       <= AC_IDLE;
      aci_prev_q <= `ACI_OFF;
      itv_q      <= 17'h00000;
      wcnt_q     <= 12'h000;
      xcnt_q     <= 22'h000000;
      cal_q      <= rc_cal_t'(`CAL_RST);
    end
    else
    begin
      aci_prev_q <= autocal_interval;
      if (!autocal_interval[1] || stop || due)
        itv_q <= 17'h00000;
      else if (tick_q)
        itv_q <= itv_q + 17'h00001;
      if (cal_wr)
        cal_q <= cal_wdata;
      case (st_q)
        AC_IDLE:
        begin
          wcnt_q <= 12'h000;
          xcnt_q <= 22'h000000;
          if ((kick || due) && !stop)
            st_q <= osc_select_request ? AC_WARM : AC_MEAS;
        end
        AC_WARM:
        begin
          if (tick_q)
            wcnt_q <= wcnt_q + 12'h001;
          if (wcnt_q == 12'(WARM_T))
          begin
            wcnt_q <= 12'h000;
            st_q   <= AC_MEAS;
          end
        end
        AC_MEAS:
        begin
          if (rc_rise)
            wcnt_q <= wcnt_q + 12'h001;
          if (xt_rise && wcnt_q != 12'h000 && !xcnt_q[21])
            xcnt_q <= xcnt_q + 22'h000001;
          if (rc_rise && wcnt_q == 12'(`AC_WIN_RC))
            st_q <= AC_LOAD;
        end
        AC_LOAD:
        begin
          if (!ac_bad)
            cal_q <= ac_new;
          st_q <= AC_IDLE;
        end
        default: st_q <= AC_IDLE;
      endcase
      if (stop && st_q != AC_IDLE)
        st_q <= AC_IDLE;
    end
  end

  // Outputs
  assign rc_cal               = cal_q;
  assign active_osc_indicator = act_rc_q;
  assign crystal_fail_status  = fstat_q;
  assign osc_fail_flag        = ofail_q;
  assign autocal_fail_flag    = afail_q;
  assign autocal_busy         = st_q != AC_IDLE;
  assign crystal_enable       = xt_en_q;
  assign irq                  = irq_q;
  assign tick_64hz            = tick_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_xt_cal_off: assert property (!act_rc_q && xt64 |=> tick_q)
    else $error("crystal tick not passed uncalibrated");
  a_neg_gate: assert property (hit && neg |=> !tick_q)
    else $error("negative step did not drop a tick");
  a_pos_pend: assert property (hit && !neg |=> add_pend_q)
    else $error("positive step not queued");
  a_pos_insert: assert property (act_rc_q && mid && add_pend_q |=> tick_q)
    else $error("positive step did not insert a tick");
  a_fail_flag: assert property (fail_set |=> osc_fail_flag && xt_failed_q)
    else $error("oscillator failure not flagged");
  a_xt_status: assert property (act_rc_q |=> crystal_fail_status)
    else $error("crystal status clear while rc in use");
  a_failover: assert property (failover_on_osc_fail && xt_failed_q |=> act_rc_q)
    else $error("no failover to rc");
  a_supply_sw: assert property (stop |=> act_rc_q && !crystal_enable)
    else $error("supply loss did not switch to rc");
  a_ac_kick: assert property (st_q == AC_IDLE && kick && !stop |=> autocal_busy)
    else $error("autocal not started");
  a_ac_fail: assert property (st_q == AC_LOAD && ac_bad && !cal_wr
                              |=> autocal_fail_flag && $stable(rc_cal))
    else $error("bad autocal changed calibration");
  a_rc_select: assert property (osc_select_request |=> act_rc_q)
    else $error("rc select ignored");
endmodule : rc_osc_cal_ctrl

/* File: tb/rc_osc_cal_tb_top.sv */
module rc_oscillator_calibration_and_failover_tb_top;
  import osc_cal_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    string       name;
    logic [15:0] exp;
  } note_t;

  logic        clk, nrst, xt_clk_in, rc_clk_in, supply_low_in, osc_select_request;
  logic        auto_switch_on_supply_loss, failover_on_osc_fail, osc_fail_irq_enable;
  logic        cal_wr, osc_fail_clr, xt_run;
  logic        autocal_fail_irq_enable, autocal_fail_clr;
  logic [1:0]  autocal_interval;
  rc_cal_t     cal_wdata, rc_cal;
  logic        active_osc_indicator, crystal_fail_status, osc_fail_flag, autocal_fail_flag;
  logic        autocal_busy, crystal_enable, irq, tick_64hz;
  logic [3:0]  xt_cnt;
  logic [1:0]  rc_cnt;
  logic [15:0] tick_cnt, t0;
  logic [31:0] rnd;
  int          num_errors = 0;
  int          num_checks = 0;
  note_t       notes[$];
  note_t       cur;

  // Short counts keep the failure and interval timers quick
  rc_osc_cal_ctrl #(.FAIL_CYC(200), .INT_LONG_T(40), .INT_SHRT_T(20)) i_dut (
    .clk                        (clk),
    .nrst                       (nrst),
    .xt_clk_in                  (xt_clk_in),
    .rc_clk_in                  (rc_clk_in),
    .supply_low_in              (supply_low_in),
    .osc_select_request         (osc_select_request),
    .auto_switch_on_supply_loss (auto_switch_on_supply_loss),
    .failover_on_osc_fail       (failover_on_osc_fail),
    .autocal_interval           (autocal_interval),
    .osc_fail_irq_enable        (osc_fail_irq_enable),
    .autocal_fail_irq_enable    (autocal_fail_irq_enable),
    .cal_wr                     (cal_wr),
    .cal_wdata                  (cal_wdata),
    .osc_fail_clr               (osc_fail_clr),
    .autocal_fail_clr           (autocal_fail_clr),
    .rc_cal                     (rc_cal),
    .active_osc_indicator       (active_osc_indicator),
    .crystal_fail_status        (crystal_fail_status),
    .osc_fail_flag              (osc_fail_flag),
    .autocal_fail_flag          (autocal_fail_flag),
    .autocal_busy               (autocal_busy),
    .crystal_enable             (crystal_enable),
    .irq                        (irq),
    .tick_64hz                  (tick_64hz)
  );

  // Clock, 50 ns period
  always #25 clk = ~clk;

  // Oscillator pins: RC period 8 clk, crystal period 32 clk while running
  always @(posedge clk)
  begin
    rc_cnt <= rc_cnt + 2'h1;
    if (rc_cnt == 2'h3) rc_clk_in <= ~rc_clk_in;
    if (xt_run) xt_cnt <= xt_cnt + 4'h1;
    if (xt_run && xt_cnt == 4'hf) xt_clk_in <= ~xt_clk_in;
    if (tick_64hz === 1'b1) tick_cnt <= tick_cnt + 16'h1;
  end

  function automatic logic [15:0] obs(string n);
    case (n)
      "osc_fail_flag": return {15'h0, osc_fail_flag};
      "irq":           return {15'h0, irq};
      "xt_fail":       return {15'h0, crystal_fail_status};
      "active":        return {15'h0, active_osc_indicator};
      "xt_en":         return {15'h0, crystal_enable};
      "busy":          return {15'h0, autocal_busy};
      "ac_fail":       return {15'h0, autocal_fail_flag};
      "rc_cal":        return rc_cal;
      default:         return tick_cnt;
    endcase
  endfunction : obs

  // Scoreboard: compare every queued note, oldest first, against settled outputs
  always @(negedge clk)
  begin
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      num_checks++;
      if (obs(cur.name) !== cur.exp)
      begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", cur.name, cur.exp, obs(cur.name));
      end
    end
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic note(string n, logic [15:0] e);
    notes.push_back('{n, e});
  endtask : note

  // Count ticks over exactly n clock edges
  task automatic window(int n, logic [15:0] e);
    @(negedge clk);
    t0 = tick_cnt;
    repeat (n - 1) @(negedge clk);
    @(posedge clk);
    note("ticks", t0 + e);
  endtask : window

  task automatic write_cal(logic [15:0] v);
    cal_wdata <= v;
    cal_wr <= 1'b1;
    @(posedge clk);
    cal_wr <= 1'b0;
  endtask : write_cal

  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // Watchdog against a hang
  initial
  begin
    repeat (80000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    {nrst, xt_clk_in, rc_clk_in, supply_low_in, osc_select_request, cal_wr} = '0;
    {auto_switch_on_supply_loss, failover_on_osc_fail, osc_fail_clr, xt_run} = '0;
    {autocal_fail_irq_enable, autocal_fail_clr} = '0;
    {autocal_interval, cal_wdata, xt_cnt, rc_cnt, tick_cnt} = '0;
    osc_fail_irq_enable = 1'b1;
    void'($urandom(74237));
    cyc(2);
    nrst <= 1'b1;
    cyc(3);
    note("osc_fail_flag", 16'h1);
    note("irq", 16'h1);
    note("xt_fail", 16'h1);
    note("active", 16'h0);
    note("rc_cal", 16'h0);
    note("busy", 16'h0);
    note("ac_fail", 16'h0);
    xt_run <= 1'b1;
    cyc(200);
    note("xt_fail", 16'h0);
    note("xt_en", 16'h1);
    osc_fail_clr <= 1'b1;
    cyc(1);
    osc_fail_clr <= 1'b0;
    cyc(3);
    note("osc_fail_flag", 16'h0);
    note("irq", 16'h0);
    repeat (4)
    begin
      rnd = $urandom;
      write_cal(rnd[15:0]);
      cyc(2);
      note("rc_cal", rnd[15:0]);
    end
    failover_on_osc_fail <= 1'b1;
    xt_run <= 1'b0;
    cyc(2600);
    note("osc_fail_flag", 16'h0);
    note("active", 16'h0);
    cyc(200);
    note("osc_fail_flag", 16'h1);
    note("irq", 16'h1);
    note("active", 16'h1);
    note("xt_fail", 16'h1);
    xt_run <= 1'b1;
    cyc(100);
    note("active", 16'h0);
    auto_switch_on_supply_loss <= 1'b1;
    supply_low_in <= 1'b1;
    cyc(10);
    note("active", 16'h1);
    note("xt_en", 16'h0);
    supply_low_in <= 1'b0;
    cyc(100);
    note("active", 16'h0);
    note("xt_en", 16'h1);
    write_cal(16'he000);
    window(32768, 16'h2);
    // Crystal-mode autocal: sim ratio is far off, so it must fail
    osc_fail_clr <= 1'b1;
    autocal_fail_irq_enable <= 1'b1;
    autocal_interval <= 2'h3;
    cyc(1);
    osc_fail_clr <= 1'b0;
    autocal_interval <= 2'h0;
    cyc(3);
    note("busy", 16'h1);
    note("irq", 16'h0);
    cyc(16500);
    note("busy", 16'h0);
    note("ac_fail", 16'h1);
    note("irq", 16'h1);
    note("rc_cal", 16'he000);
    autocal_fail_clr <= 1'b1;
    cyc(1);
    autocal_fail_clr <= 1'b0;
    cyc(3);
    note("ac_fail", 16'h0);
    note("irq", 16'h0);
    osc_select_request <= 1'b1;
    cyc(10);
    note("active", 16'h1);
    note("xt_fail", 16'h1);
    note("xt_en", 16'h0);
    write_cal(16'h0000);
    cyc(8);
    window(1024, 16'h40);
    for (int r = 3; r >= 0; r--)
    begin
      write_cal({r[1:0], 14'h2000});
      cyc(8);
      window(1024, 16'h40 - (16'h1 << r));
    end
    // Positive offset inserts one tick per period
    write_cal({2'h3, 14'h1000});
    cyc(40);
    window(1024, 16'h44);
    autocal_interval <= 2'h2;
    cyc(3);
    note("busy", 16'h1);
    note("xt_en", 16'h1);
    cyc(2);
    stop_test();
  end
endmodule : rc_oscillator_calibration_and_failover_tb_top
